//--- dv/irq_priority_regs_bank_tb_top.sv
`timescale 1ns/1ps
module irq_priority_regs_bank_tb_top
    import irq_prio_pkg::*;
;
    logic            pclk    = 0;
    logic            presetn = 0;
    logic            clk_en  = 1;
    logic            psel    = 0;
    logic            penable = 0;
    logic            pwrite  = 0;
    logic [7:0]      paddr   = '0;
    logic [31:0]     pwdata  = '0;
    logic [3:0]      pstrb   = '0;
    logic [NSRC-1:0] src_flag = '0;
    wire  [31:0]     prdata;
    wire             pready;
    wire             pslverr;
    wire  [NSRC-1:0] req_active;
    wire  [NSRC-1:0][2:0] pv;
    wire  [2:0]      top_level;
    logic [2:0]      ep [NSRC];
    logic [NSRC-1:0] hold_req;
    logic [32:0]     q [$];
    logic [15:0]     rnd = 16'h35b6;
    logic [7:0]      a;
    int              failures = 0;
    int              samples_checked = 0;
    localparam logic [7:0] AD [7] = '{PCTRL7_ADDR, PCTRL8_ADDR,
        PCTRL9_ADDR, PCTRL10_ADDR, PCTRL11_ADDR, PCTRL12_ADDR, PCTRL15_ADDR};
    localparam logic [31:0] PAT [3] = '{32'hffffffff, 32'h11111111, 32'h0};

    irq_priority_regs_bank dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_flag(src_flag), .req_active(req_active),
        .uart_b_tx_priority(pv[0]), .uart_b_rx_priority(pv[1]),
        .ext_irq_b_priority(pv[2]), .timer_five_priority(pv[3]),
        .spi_b_event_priority(pv[4]), .spi_b_fault_priority(pv[5]),
        .capture_five_priority(pv[6]), .capture_four_priority(pv[7]),
        .capture_three_priority(pv[8]), .compare_five_priority(pv[9]),
        .parallel_port_priority(pv[10]), .i2c_b_master_priority(pv[11]),
        .i2c_b_slave_priority(pv[12]), .calendar_clock_priority(pv[13])
    );
    prio_arbiter_model arb (
        .req_active(req_active), .prio(pv), .top_level(top_level)
    );

    always #5 pclk = ~pclk;

    function logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr

    function logic [32:0] rd_exp(input logic [7:0] ad);
        logic [32:0] r;
        r = {1'b1, 32'h0};
        for (int k = 0; k < 7; k++) if (AD[k] == ad) r[32] = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (SRC_ADDR[i] == ad) r[SRC_LSB[i] +: 3] = ep[i];
        end
        return r;
    endfunction : rd_exp

    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task print_verdict;
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
             input logic [3:0] s);
        int n;
        if (!w) q.push_back(rd_exp(ad));
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            disable run;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (w && SRC_ADDR[i] == ad && s[SRC_LSB[i] / 8])
                ep[i] = d[SRC_LSB[i] +: 3];
        end
        @(posedge pclk);
    endtask : apb

    task flags(input logic [NSRC-1:0] f);
        logic [NSRC-1:0] er;
        logic [2:0]      et;
        er = '0;
        et = PRIO_OFF;
        src_flag <= f;
        for (int i = 0; i < NSRC; i++) begin
            if (f[i] && ep[i] != PRIO_OFF) begin
                er[i] = 1'b1;
                if (ep[i] > et) et = ep[i];
            end
        end
        hold_req = er;
        @(posedge pclk);
        @(negedge pclk);
        chk("req_active", req_active, er);
        chk("top_level", top_level, et);
        for (int i = 0; i < NSRC; i++) chk("priority", pv[i], ep[i]);
        @(posedge pclk);
    endtask : flags

    // Read answers against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
            chk("prdata", prdata, q[0][31:0]);
            chk("pslverr", pslverr, q[0][32]);
            void'(q.pop_front());
        end
    end

    initial begin
        for (int i = 0; i < NSRC; i++) ep[i] = PRIO_RESET;
        begin : run
            repeat (5) @(posedge pclk);
            presetn <= 1'b1;
            for (int k = 0; k < 7; k++) apb(0, AD[k], 32'h0, 4'hf);
            flags('1);
            for (int p = 0; p < 3; p++) begin
                for (int k = 0; k < 7; k++) begin
                    apb(1, AD[k], PAT[p], 4'hf);
                    apb(0, AD[k], 32'h0, 4'hf);
                end
                rnd = lfsr(rnd);
                flags(rnd[13:0] | 14'h0001);
            end
            for (int t = 0; t < 30; t++) begin
                rnd = lfsr(rnd);
                a = AD[rnd % 7];
                apb(1, a, {rnd, lfsr(rnd)}, rnd[7:4]);
                apb(0, a, 32'h0, 4'hf);
                rnd = lfsr(rnd);
                flags(rnd[13:0]);
            end
            apb(1, 8'h04, 32'hffffffff, 4'hf);
            apb(0, 8'h04, 32'h0, 4'hf);
            apb(0, 8'h40, 32'h0, 4'hf);
            flags('1);
            // Frozen by clock enable
            clk_en <= 1'b0;
            src_flag <= '0;
            repeat (3) @(posedge pclk);
            chk("req_frozen", req_active, hold_req);
            clk_en <= 1'b1;
            flags('0);
            chk("queue", q.size(), 0);
        end
        print_verdict();
    end
endmodule : irq_priority_regs_bank_tb_top

//--- dv/prio_arbiter_model.sv
`timescale 1ns/1ps
module prio_arbiter_model
    import irq_prio_pkg::*;
(
    input  wire logic [NSRC-1:0] req_active,
    input  wire logic [NSRC-1:0][2:0] prio,
    output logic      [2:0]      top_level
);
    // Highest level among raised requests
    always_comb begin
        top_level = PRIO_OFF;
        for (int i = 0; i < NSRC; i++) begin
            if (req_active[i] && prio[i] > top_level) begin
                top_level = prio[i];
            end
        end
    end
endmodule : prio_arbiter_model

//--- include/irq_prio_pkg.sv
package irq_prio_pkg;

    // Bus and field geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NSRC   = 14;
    localparam int PRIO_W = 3;
    localparam int LANE_W = 8;

    // Priority encodings
    localparam logic [2:0] PRIO_OFF   = 3'h0;
    localparam logic [2:0] PRIO_MIN   = 3'h1;
    localparam logic [2:0] PRIO_MAX   = 3'h7;
    localparam logic [2:0] PRIO_RESET = 3'h4;

    // Register byte addresses
    localparam logic [7:0] PCTRL7_ADDR  = 8'h1c;
    localparam logic [7:0] PCTRL8_ADDR  = 8'h20;
    localparam logic [7:0] PCTRL9_ADDR  = 8'h24;
    localparam logic [7:0] PCTRL10_ADDR = 8'h28;
    localparam logic [7:0] PCTRL11_ADDR = 8'h2c;
    localparam logic [7:0] PCTRL12_ADDR = 8'h30;
    localparam logic [7:0] PCTRL15_ADDR = 8'h3c;

    // Source indices
    localparam int SRC_UART_B_TX  = 0;
    localparam int SRC_UART_B_RX  = 1;
    localparam int SRC_EXT_IRQ_B  = 2;
    localparam int SRC_TIMER_FIVE = 3;
    localparam int SRC_SPI_B_EVT  = 4;
    localparam int SRC_SPI_B_FLT  = 5;
    localparam int SRC_CAP_FIVE   = 6;
    localparam int SRC_CAP_FOUR   = 7;
    localparam int SRC_CAP_THREE  = 8;
    localparam int SRC_CMP_FIVE   = 9;
    localparam int SRC_PAR_PORT   = 10;
    localparam int SRC_I2C_B_MST  = 11;
    localparam int SRC_I2C_B_SLV  = 12;
    localparam int SRC_CALENDAR   = 13;

    // Register holding each source
    localparam logic [7:0] SRC_ADDR [NSRC] = '{
        PCTRL7_ADDR,  PCTRL7_ADDR,  PCTRL7_ADDR,  PCTRL7_ADDR,
        PCTRL8_ADDR,  PCTRL8_ADDR,
        PCTRL9_ADDR,  PCTRL9_ADDR,  PCTRL9_ADDR,
        PCTRL10_ADDR, PCTRL11_ADDR,
        PCTRL12_ADDR, PCTRL12_ADDR, PCTRL15_ADDR
    };

    // Low bit of each field within its register
    localparam int SRC_LSB [NSRC] = '{
        12, 8, 4, 0,
        4, 0,
        12, 8, 4,
        4, 4,
        8, 4, 8
    };

endpackage : irq_prio_pkg

//--- logic/irq_priority_regs_bank.sv
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Each priority field is three bits; 111 gives level 7, the highest.
// - Field value 000 disables its source; it never raises a request.
// - Field value 001 gives level 1; 001 to 111 map to levels 1-7.
// - Bits outside priority fields ignore writes and read as zero.
// - Fields are read/write and reset to 100, level 4.
// - UART B transmit priority in bits 14:12 of register 7.
// - UART B receive priority in bits 10:8 of register 7.
// - External interrupt B priority in bits 6:4 of register 7.
// - Timer five priority in bits 2:0 of register 7.
// - SPI B event priority in bits 6:4 of register 8.
// - SPI B fault priority in bits 2:0 of register 8.
// - Capture five priority in bits 14:12 of register 9.
// - Capture four priority in bits 10:8 of register 9.
// - Capture three priority in bits 6:4 of register 9.
// - Compare five priority in bits 6:4 of register 10.
// - Parallel port priority in bits 6:4 of register 11.
// - I2C B master priority in bits 10:8 of register 12.
// - I2C B slave priority in bits 6:4 of register 12.
// - Calendar clock priority in bits 10:8 of register 15.
module irq_priority_regs_bank
    import irq_prio_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [AW-1:0]     paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NSRC-1:0]   src_flag,
    output logic      [NSRC-1:0]   req_active,
    output logic      [2:0]        uart_b_tx_priority,
    output logic      [2:0]        uart_b_rx_priority,
    output logic      [2:0]        ext_irq_b_priority,
    output logic      [2:0]        timer_five_priority,
    output logic      [2:0]        spi_b_event_priority,
    output logic      [2:0]        spi_b_fault_priority,
    output logic      [2:0]        capture_five_priority,
    output logic      [2:0]        capture_four_priority,
    output logic      [2:0]        capture_three_priority,
    output logic      [2:0]        compare_five_priority,
    output logic      [2:0]        parallel_port_priority,
    output logic      [2:0]        i2c_b_master_priority,
    output logic      [2:0]        i2c_b_slave_priority,
    output logic      [2:0]        calendar_clock_priority
);

    logic [PRIO_W-1:0] prio_q [NSRC];
    logic [DATA_W-1:0] prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    logic [NSRC-1:0]   req_q;
    logic              setup;
    logic              commit;
    logic [7:0]        addr8;

    // Register decode
    function automatic logic addr_hit(input logic [7:0] a);
        logic h;
        h = 1'b0;
        for (int i = 0; i < NSRC; i++) begin
            if (a == SRC_ADDR[i]) begin
                h = 1'b1;
            end
        end
        return h;
    endfunction : addr_hit

    // Word image of a register; unused bits stay zero
    function automatic logic [DATA_W-1:0] read_word(input logic [7:0] a);
        logic [DATA_W-1:0] w;
        w = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (a == SRC_ADDR[i]) begin
                w[SRC_LSB[i] +: PRIO_W] = prio_q[i];
            end
        end
        return w;
    endfunction : read_word

    assign addr8  = 8'(paddr);
    assign setup  = clk_en && psel && !penable;
    assign commit = clk_en && psel && penable && pready_q;

    // Bus answer, one wait-free access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else if (clk_en) begin
            pready_q  <= setup;
            pslverr_q <= setup && !addr_hit(addr8);
            if (setup && !pwrite) begin
                prdata_q <= read_word(addr8);
            end else begin
                prdata_q <= '0;
            end
        end
    end

    // Priority fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NSRC; i++) begin
                prio_q[i] <= PRIO_RESET;
            end
        end else if (commit && pwrite) begin
            for (int i = 0; i < NSRC; i++) begin
                if (addr8 == SRC_ADDR[i] && pstrb[SRC_LSB[i] / LANE_W]) begin
                    prio_q[i] <= pwdata[SRC_LSB[i] +: PRIO_W];
                end
            end
        end
    end

    // Request gating toward arbitration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < NSRC; i++) begin
                req_q[i] <= src_flag[i] && (prio_q[i] != PRIO_OFF);
            end
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign req_active = req_q;

    // Levels presented continuously
    assign uart_b_tx_priority      = prio_q[SRC_UART_B_TX];
    assign uart_b_rx_priority      = prio_q[SRC_UART_B_RX];
    assign ext_irq_b_priority      = prio_q[SRC_EXT_IRQ_B];
    assign timer_five_priority     = prio_q[SRC_TIMER_FIVE];
    assign spi_b_event_priority    = prio_q[SRC_SPI_B_EVT];
    assign spi_b_fault_priority    = prio_q[SRC_SPI_B_FLT];
    assign capture_five_priority   = prio_q[SRC_CAP_FIVE];
    assign capture_four_priority   = prio_q[SRC_CAP_FOUR];
    assign capture_three_priority  = prio_q[SRC_CAP_THREE];
    assign compare_five_priority   = prio_q[SRC_CMP_FIVE];
    assign parallel_port_priority  = prio_q[SRC_PAR_PORT];
    assign i2c_b_master_priority   = prio_q[SRC_I2C_B_MST];
    assign i2c_b_slave_priority    = prio_q[SRC_I2C_B_SLV];
    assign calendar_clock_priority = prio_q[SRC_CALENDAR];

    // Checks
    logic past_valid_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            past_valid_q <= 1'b0;
        end else if (clk_en) begin
            past_valid_q <= 1'b1;
        end
    end

    sequence s_setup;
        setup;
    endsequence

    sequence s_access;
        psel && penable && pready;
    endsequence

    sequence s_write_reg7;
        commit && pwrite && addr8 == PCTRL7_ADDR && pstrb[1];
    endsequence

    sequence s_write_reg7_lo;
        commit && pwrite && addr8 == PCTRL7_ADDR && pstrb[0];
    endsequence

    sequence s_write_reg8;
        commit && pwrite && addr8 == PCTRL8_ADDR && pstrb[0];
    endsequence

    sequence s_write_reg9_hi;
        commit && pwrite && addr8 == PCTRL9_ADDR && pstrb[1];
    endsequence

    sequence s_write_reg9_lo;
        commit && pwrite && addr8 == PCTRL9_ADDR && pstrb[0];
    endsequence

    sequence s_write_reg10;
        commit && pwrite && addr8 == PCTRL10_ADDR && pstrb[0];
    endsequence

    sequence s_write_reg11;
        commit && pwrite && addr8 == PCTRL11_ADDR && pstrb[0];
    endsequence

    sequence s_write_reg12_hi;
        commit && pwrite && addr8 == PCTRL12_ADDR && pstrb[1];
    endsequence

    sequence s_write_reg12_lo;
        commit && pwrite && addr8 == PCTRL12_ADDR && pstrb[0];
    endsequence

    reset_level_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !past_valid_q |-> timer_five_priority == PRIO_RESET
            && calendar_clock_priority == PRIO_RESET)
        else $error("priority field not at reset level");

    bus_ready_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_setup |=> pready ##1 !pready)
        else $error("ready not a single cycle after setup");

    tx_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write_reg7 |=> uart_b_tx_priority == $past(pwdata[14:12]))
        else $error("transmit priority not written from 14:12");

    rx_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write_reg7 |=> uart_b_rx_priority == $past(pwdata[10:8]))
        else $error("receive priority not written from 10:8");

    cal_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && pwrite && addr8 == PCTRL15_ADDR && pstrb[1]
        |=> calendar_clock_priority == $past(pwdata[10:8]))
        else $error("calendar priority not written from 10:8");

    disabled_src_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && timer_five_priority == PRIO_OFF
        |=> !req_active[SRC_TIMER_FIVE])
        else $error("disabled source raised a request");

    enabled_src_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_en && src_flag[SRC_CALENDAR]
            && calendar_clock_priority >= PRIO_MIN
        |=> req_active[SRC_CALENDAR])
        else $error("enabled source did not raise a request");

    reserved_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_setup ##1 (s_access and (!pwrite && paddr == PCTRL15_ADDR))
        |-> prdata[31:11] == '0 && prdata[7:0] == '0)
        else $error("unimplemented bits read nonzero");

    read_back_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_setup ##1 (s_access and (!pwrite && paddr == PCTRL8_ADDR))
        |-> prdata[6:4] == spi_b_event_priority
            && prdata[2:0] == spi_b_fault_priority)
        else $error("read data does not show priority fields");

    stable_level_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        past_valid_q && !$past(commit)
        |-> $stable(parallel_port_priority))
        else $error("priority changed without a write");

    unmapped_err_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_setup ##1 (s_access and paddr < PCTRL7_ADDR) |-> pslverr)
        else $error("unmapped address answered without error");

    ext_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write_reg7_lo |=> ext_irq_b_priority == $past(pwdata[6:4]))
        else $error("external priority not written from 6:4");

    timer_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write_reg7_lo |=> timer_five_priority == $past(pwdata[2:0]))
        else $error("timer priority not written from 2:0");

    spi_evt_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write_reg8 |=> spi_b_event_priority == $past(pwdata[6:4]))
        else $error("spi event priority not written from 6:4");

    spi_flt_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write_reg8 |=> spi_b_fault_priority == $past(pwdata[2:0]))
        else $error("spi fault priority not written from 2:0");

    cap_five_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write_reg9_hi |=> capture_five_priority == $past(pwdata[14:12]))
        else $error("capture five priority not written from 14:12");

    cap_four_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write_reg9_hi |=> capture_four_priority == $past(pwdata[10:8]))
        else $error("capture four priority not written from 10:8");

    cap_three_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write_reg9_lo |=> capture_three_priority == $past(pwdata[6:4]))
        else $error("capture three priority not written from 6:4");

    cmp_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write_reg10 |=> compare_five_priority == $past(pwdata[6:4]))
        else $error("compare priority not written from 6:4");

    par_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write_reg11 |=> parallel_port_priority == $past(pwdata[6:4]))
        else $error("parallel port priority not written from 6:4");

    i2c_mst_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write_reg12_hi |=> i2c_b_master_priority == $past(pwdata[10:8]))
        else $error("i2c master priority not written from 10:8");

    i2c_slv_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write_reg12_lo |=> i2c_b_slave_priority == $past(pwdata[6:4]))
        else $error("i2c slave priority not written from 6:4");

    lane_block_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && pwrite && addr8 == PCTRL7_ADDR && !pstrb[1]
        |=> $stable(uart_b_tx_priority))
        else $error("transmit priority written with lane strobe low");

    cal_lane_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && pwrite && addr8 == PCTRL15_ADDR && !pstrb[1]
        |=> $stable(calendar_clock_priority))
        else $error("calendar priority written with lane strobe low");

    unmapped_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && pwrite && addr8 < PCTRL7_ADDR
        |=> $stable(timer_five_priority) && $stable(uart_b_tx_priority))
        else $error("write to unmapped address changed a field");

    reg8_upper_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_setup ##1 (s_access and (!pwrite && paddr == PCTRL8_ADDR))
        |-> prdata[31:7] == '0 && prdata[3] == 1'b0)
        else $error("unimplemented bits of register 8 read nonzero");

    reg7_gaps_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_setup ##1 (s_access and (!pwrite && paddr == PCTRL7_ADDR))
        |-> prdata[31:15] == '0 && !prdata[11] && !prdata[7] && !prdata[3])
        else $error("unimplemented bits of register 7 read nonzero");

    upper_half_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_setup ##1 s_access |-> prdata[31:16] == '0)
        else $error("upper half of read data nonzero");

    idle_rdata_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == '0)
        else $error("read data not zero outside an access");

    req_reset_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !past_valid_q |-> req_active == '0 && !pready && !pslverr)
        else $error("request or bus answer active after reset");

    mapped_ok_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_setup ##1 (s_access and paddr == PCTRL7_ADDR) |-> !pslverr)
        else $error("mapped register answered with error");

endmodule : irq_priority_regs_bank
